// ===== shared/rscfg_pkg.sv
// constants for the reset strap configuration sampler
package rscfg_pkg;

  // ************************************************************
  // strap vector layout
  // ************************************************************
  localparam int STRAP_W      = 10;
  localparam int ST_BURST     = 0;  // burst_in_progress_strap
  localparam int ST_SIZE1     = 1;  // size_bit_one_strap
  localparam int ST_SDA       = 2;  // serial data line level
  localparam int ST_EEPROM    = 3;  // eeprom_enable_strap
  localparam int ST_TMODE_LO  = 4;  // test_mode_straps[0]
  localparam int ST_TMODE_HI  = 5;  // test_mode_straps[1]
  localparam int ST_BM        = 6;  // bus_master_enable_strap
  localparam int ST_ARB       = 7;  // arbiter_enable_strap
  localparam int ST_DIS       = 8;  // pci_disable_strap
  localparam int ST_SPARE     = 9;  // unused, reads zero
  localparam logic [STRAP_W-1:0] STRAP_RST = 10'h000;

  // ************************************************************
  // synchroniser
  // ************************************************************
  localparam int SYNC_STAGES  = 3;

  // ************************************************************
  // register offsets (byte addresses)
  // ************************************************************
  localparam logic [7:0] OFS_CMD_STAT  = 8'h00;
  localparam logic [7:0] OFS_MISC2     = 8'h04;
  localparam logic [7:0] OFS_STRAP_STS = 8'h08;
  localparam logic [7:0] OFS_INT_CTL   = 8'h0c;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int BIT_BUS_MASTER = 2;   // in command/status
  localparam int BIT_PCI_DISABLE_STRAP    = 0;   // in second misc control
  localparam int BIT_HOST_MODE  = 0;   // in interrupt control
  localparam int BIT_PCI_INT    = 1;   // in interrupt control, read only
  localparam int BIT_LOC_INT    = 2;   // in interrupt control, read only
  localparam int BIT_M68K       = 10;  // in strap status
  localparam int BIT_EE_PRESENT = 11;  // in strap status
  localparam logic RST_BUS_MASTER = 1'b0;
  localparam logic RST_PCI_DISABLE_STRAP    = 1'b0;
  localparam logic RST_HOST_MODE  = 1'b0;

  // ************************************************************
  // test mode encodings
  // ************************************************************
  localparam logic [1:0] TMODE_NORMAL   = 2'h0;
  localparam logic [1:0] TMODE_NANDTREE = 2'h2;

endpackage

// ===== shared/rscfg_strap_if.sv
// captured strap values passed from the sampler to the core
`timescale 1ns/1ps
interface rscfg_strap_if;
  import rscfg_pkg::*;
  logic               loaded;  // one cycle pulse, straps just renewed
  logic [STRAP_W-1:0] straps;  // captured levels, held between resets

  modport sampler (output loaded, output straps);
  modport core    (input loaded, input straps);
endinterface

// ===== logic/rscfg_sampler.sv
// strap synchroniser and capture on reset release
`timescale 1ns/1ps
module rscfg_sampler
  import rscfg_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic [STRAP_W-1:0] strap_pins,
  input  wire logic               pci_rst_n,
  input  wire logic               local_rst_n,
  rscfg_strap_if.sampler          cfg
);
  localparam int PIN_W = STRAP_W + 2;
  localparam logic [PIN_W-1:0] PIN_RST = 12'h000;

  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;
  logic [PIN_W-1:0] sync3;
  logic [PIN_W-1:0] filt;

  // ************************************************************
  // filtering
  // ************************************************************
  // a level counts only once stages two and three agree; stage one
  // feeds nothing but stage two
  wire [PIN_W-1:0] pins_raw  = {local_rst_n, pci_rst_n, strap_pins};
  wire [PIN_W-1:0] agree     = ~(sync2 ^ sync3);
  wire [PIN_W-1:0] next_filt = (sync3 & agree) | (filt & ~agree);

  // resets start as asserted so the first release is seen as a rise
  wire pci_rise = next_filt[PIN_W-2] & ~filt[PIN_W-2];
  wire loc_rise = next_filt[PIN_W-1] & ~filt[PIN_W-1];
  wire capture  = pci_rise | loc_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= PIN_RST;
      sync2 <= PIN_RST;
      sync3 <= PIN_RST;
      filt  <= PIN_RST;
    end else begin
      sync1 <= pins_raw;
      sync2 <= sync1;
      sync3 <= sync2;
      filt  <= next_filt;
    end
  end

  // ************************************************************
  // capture
  // ************************************************************
  // straps reuse functional pins, so only the level seen during
  // reset is kept; later toggling is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg.straps <= STRAP_RST;
      cfg.loaded <= 1'b0;
    end else begin
      if (capture) begin
        cfg.straps <= filt[STRAP_W-1:0];
      end
      cfg.loaded <= capture;
    end
  end

  AST_LOAD_STRAPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    capture |=> (cfg.straps == $past(filt[STRAP_W-1:0])) && cfg.loaded)
    else $error("straps not loaded on reset release");

  AST_HOLD_STRAPS: assert property (
    @(posedge clk) disable iff (!rst_n)
    !capture |=> $stable(cfg.straps) && !cfg.loaded)
    else $error("captured straps changed outside a reset release");

endmodule

// ===== logic/rscfg_top.sv
// reset strap configuration sampler with interrupt routing and registers
`timescale 1ns/1ps
// Operation
// - sample straps on both reset releases
// - burst high, size one low selects 68k
// - test straps zero normal, else test mode
// - bus master strap high sets master bit
// - strap low, master only after software write
// - arbiter strap high enables internal arbiter
// - disable strap high sets disable status bit
// - retry every target access while disabled
// - host use, PCI interrupt drives local
// - adapter use, local interrupt drives PCI
// - no target completion until disable cleared
module rscfg_top
  import rscfg_pkg::*;
(
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        BURST_IN_PROGRESS_STRAP,
  input  wire logic        SIZE_BIT_ONE_STRAP,
  input  wire logic        SERIAL_DATA_STRAP,
  input  wire logic        EEPROM_ENABLE_STRAP,
  input  wire logic [1:0]  TEST_MODE_STRAPS,
  input  wire logic        BUS_MASTER_ENABLE_STRAP,
  input  wire logic        ARBITER_ENABLE_STRAP,
  input  wire logic        PCI_DISABLE_STRAP,
  input  wire logic        PCI_RST_N,
  input  wire logic        LOCAL_RESET_IN_N,
  input  wire logic        PCI_INT_N_I,
  output logic             PCI_INT_N_O,
  output logic             PCI_INT_N_OE,
  input  wire logic        LOCAL_INT_N_I,
  output logic             LOCAL_INT_N_O,
  output logic             LOCAL_INT_N_OE,
  input  wire logic        TGT_REQ,
  output logic             TGT_RETRY,
  output logic             TGT_GO,
  output logic             M68K_MODE,
  output logic             EEPROM_PRESENT,
  output logic             TEST_TRISTATE,
  output logic             TEST_NAND_TREE,
  output logic             ARBITER_ENABLE,
  output logic             PCI_ENABLE,
  output logic             PCI_INITIATOR_EN,
  output logic             CONFIG_LOADED
);

  // ************************************************************
  // strap capture
  // ************************************************************
  rscfg_strap_if cfg ();

  wire [STRAP_W-1:0] strap_pins = {
    1'b0,
    PCI_DISABLE_STRAP,
    ARBITER_ENABLE_STRAP,
    BUS_MASTER_ENABLE_STRAP,
    TEST_MODE_STRAPS,
    EEPROM_ENABLE_STRAP,
    SERIAL_DATA_STRAP,
    SIZE_BIT_ONE_STRAP,
    BURST_IN_PROGRESS_STRAP
  };

  rscfg_sampler u_sampler (
    .clk         (CORE_CLK),
    .rst_n       (RST_N),
    .strap_pins  (strap_pins),
    .pci_rst_n   (PCI_RST_N),
    .local_rst_n (LOCAL_RESET_IN_N),
    .cfg         (cfg.sampler)
  );

  // ************************************************************
  // decoded operating mode
  // ************************************************************
  logic        bus_master_bit;
  logic        pci_disable_strap_bit;
  logic        host_mode;
  logic        loaded_seen;
  logic [31:0] rd_data;
  logic        ack;

  wire [1:0] tmode     = cfg.straps[ST_TMODE_HI:ST_TMODE_LO];
  wire       test_any  = tmode != TMODE_NORMAL;
  wire       m68k_mode = cfg.straps[ST_BURST] & ~cfg.straps[ST_SIZE1];
  // an eeprom only counts when both its enable and the data line sat high
  wire       ee_present = cfg.straps[ST_EEPROM] & cfg.straps[ST_SDA];

  assign M68K_MODE        = m68k_mode;
  assign EEPROM_PRESENT   = ee_present;
  assign TEST_NAND_TREE   = tmode == TMODE_NANDTREE;
  assign TEST_TRISTATE    = test_any & (tmode != TMODE_NANDTREE);
  assign ARBITER_ENABLE   = cfg.straps[ST_ARB];
  assign PCI_ENABLE       = ~pci_disable_strap_bit;
  assign PCI_INITIATOR_EN = bus_master_bit;
  assign CONFIG_LOADED    = loaded_seen;

  // ************************************************************
  // target gate
  // ************************************************************
  // handshake answers are combinational so a retry lands in the
  // same cycle as the request
  assign TGT_RETRY = TGT_REQ & pci_disable_strap_bit;
  assign TGT_GO    = TGT_REQ & ~pci_disable_strap_bit;

  // ************************************************************
  // interrupt pin synchronisers
  // ************************************************************
  logic [1:0] int_s1;
  logic [1:0] int_s2;
  logic [1:0] int_s3;
  logic [1:0] int_filt;
  logic       pci_int_oe;
  logic       loc_int_oe;

  wire [1:0] int_agree     = ~(int_s2 ^ int_s3);
  wire [1:0] next_int_filt = (int_s3 & int_agree) | (int_filt & ~int_agree);
  wire       pci_int_act   = ~int_filt[0];
  wire       loc_int_act   = ~int_filt[1];

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      int_s1   <= 2'h3;
      int_s2   <= 2'h3;
      int_s3   <= 2'h3;
      int_filt <= 2'h3;
    end else begin
      int_s1   <= {LOCAL_INT_N_I, PCI_INT_N_I};
      int_s2   <= int_s1;
      int_s3   <= int_s2;
      int_filt <= next_int_filt;
    end
  end

  // ************************************************************
  // interrupt routing
  // ************************************************************
  // each pin is an input in one use and a driven output in the other,
  // so the driven side's own input is never looked at; test modes
  // release both pins
  wire next_loc_oe = host_mode & pci_int_act & ~test_any;
  wire next_pci_oe = ~host_mode & loc_int_act & ~test_any;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      loc_int_oe <= 1'b0;
      pci_int_oe <= 1'b0;
    end else begin
      loc_int_oe <= next_loc_oe;
      pci_int_oe <= next_pci_oe;
    end
  end

  // open-drain pins pull low only
  assign LOCAL_INT_N_O  = 1'b0;
  assign LOCAL_INT_N_OE = loc_int_oe;
  assign PCI_INT_N_O    = 1'b0;
  assign PCI_INT_N_OE   = pci_int_oe;

  // ************************************************************
  // wishbone decode
  // ************************************************************
  wire wb_req    = WB_CYC_I & WB_STB_I;
  wire wb_start  = wb_req & ~ack;
  wire wb_wr     = wb_req & ack & WB_WE_I & WB_SEL_I[0];
  wire hit_cmd   = WB_ADR_I[7:2] == OFS_CMD_STAT[7:2];
  wire hit_misc2 = WB_ADR_I[7:2] == OFS_MISC2[7:2];
  wire hit_strap = WB_ADR_I[7:2] == OFS_STRAP_STS[7:2];
  wire hit_int   = WB_ADR_I[7:2] == OFS_INT_CTL[7:2];
  wire wr_cmd    = wb_wr & hit_cmd;
  wire wr_misc2  = wb_wr & hit_misc2;
  wire wr_int    = wb_wr & hit_int;

  // read mux; unmapped words read zero
  wire [31:0] rd_cmd   = 32'(bus_master_bit) << BIT_BUS_MASTER;
  wire [31:0] rd_misc2 = 32'(pci_disable_strap_bit) << BIT_PCI_DISABLE_STRAP;
  wire [31:0] rd_strap = 32'(cfg.straps)
                       | (32'(m68k_mode) << BIT_M68K)
                       | (32'(ee_present) << BIT_EE_PRESENT);
  wire [31:0] rd_int   = (32'(host_mode) << BIT_HOST_MODE)
                       | (32'(pci_int_act) << BIT_PCI_INT)
                       | (32'(loc_int_act) << BIT_LOC_INT);
  wire [31:0] next_rd  = hit_cmd   ? rd_cmd
                       : hit_misc2 ? rd_misc2
                       : hit_strap ? rd_strap
                       : hit_int   ? rd_int
                       : 32'h0000_0000;

  // ack one cycle after the request, read data captured with it
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack     <= 1'b0;
      rd_data <= 32'h0000_0000;
    end else begin
      ack <= wb_start;
      if (wb_start) begin
        rd_data <= next_rd;
      end
    end
  end

  assign WB_ACK_O = ack;
  assign WB_DAT_O = rd_data;

  // ************************************************************
  // control registers
  // ************************************************************
  // a strap load beats a software write in the same cycle, so a
  // disable caught at reset is never lost to a racing clear
  wire next_bm  = cfg.loaded ? cfg.straps[ST_BM]
                : wr_cmd     ? WB_DAT_I[BIT_BUS_MASTER]
                : bus_master_bit;
  wire next_dis = cfg.loaded ? cfg.straps[ST_DIS]
                : (wr_misc2 & ~WB_DAT_I[BIT_PCI_DISABLE_STRAP]) ? 1'b0
                : pci_disable_strap_bit;
  wire next_host = wr_int ? WB_DAT_I[BIT_HOST_MODE] : host_mode;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bus_master_bit <= RST_BUS_MASTER;
      pci_disable_strap_bit    <= RST_PCI_DISABLE_STRAP;
      host_mode      <= RST_HOST_MODE;
      loaded_seen    <= 1'b0;
    end else begin
      bus_master_bit <= next_bm;
      pci_disable_strap_bit    <= next_dis;
      host_mode      <= next_host;
      loaded_seen    <= loaded_seen | cfg.loaded;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  AST_BM_FROM_STRAP: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    cfg.loaded && cfg.straps[ST_BM] |=> PCI_INITIATOR_EN)
    else $error("master bit not set by strap");

  AST_BM_NEEDS_WRITE: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $rose(bus_master_bit) |-> $past(cfg.loaded) || $past(wr_cmd))
    else $error("master bit rose without strap or write");

  AST_ARB_FROM_LOAD: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $changed(ARBITER_ENABLE) |-> $past(cfg.loaded, 1) || cfg.loaded)
    else $error("arbiter enable changed outside a strap load");

  AST_DIS_FROM_STRAP: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    cfg.loaded && cfg.straps[ST_DIS] |=> pci_disable_strap_bit && !PCI_ENABLE)
    else $error("disable strap did not set status bit");

  AST_RETRY_WHILE_DIS: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    TGT_REQ && pci_disable_strap_bit |-> TGT_RETRY && !TGT_GO)
    else $error("target access not retried while disabled");

  AST_DIS_STICKY: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    pci_disable_strap_bit && !cfg.loaded && !wr_misc2 |=> pci_disable_strap_bit)
    else $error("disable bit cleared without software");

  AST_HOST_INT: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    host_mode && pci_int_act && !test_any |=> LOCAL_INT_N_OE && !PCI_INT_N_OE)
    else $error("host use did not forward PCI interrupt");

  AST_ADAPTER_INT: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    !host_mode && loc_int_act && !test_any |=> PCI_INT_N_OE && !LOCAL_INT_N_OE)
    else $error("adapter use did not forward local interrupt");

  AST_TEST_RELEASE: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    test_any |=> !PCI_INT_N_OE && !LOCAL_INT_N_OE)
    else $error("pins driven in test mode");

  AST_MODE_68K: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    cfg.loaded |-> M68K_MODE == (cfg.straps[ST_BURST] && !cfg.straps[ST_SIZE1]))
    else $error("68k mode does not follow straps");

  AST_WB_ACK_ONCE: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held two cycles");

endmodule

// ===== testbench/rscfg_board.sv
// board model: strap resistors, reset sources and interrupt pull-ups
`timescale 1ns/1ps
module rscfg_board (
  input  wire logic       clk,
  input  wire logic       pci_pull,
  input  wire logic       loc_pull,
  input  wire logic       pci_int_oe,
  input  wire logic       pci_int_o,
  input  wire logic       loc_int_oe,
  input  wire logic       loc_int_o,
  output logic [9:0]      strap,
  output logic            pci_rst_n,
  output logic            loc_rst_n,
  output logic            pci_int_n,
  output logic            loc_int_n
);
  // power-up: pci reset held, local reset pulled high
  initial begin
    strap = 10'h000;
    pci_rst_n = 1'b0;
    loc_rst_n = 1'b1;
  end

  // open-drain wires with pull-ups; any party pulling low wins
  assign pci_int_n = ~((pci_int_oe & ~pci_int_o) | pci_pull);
  assign loc_int_n = ~((loc_int_oe & ~loc_int_o) | loc_pull);

  // one reset pulse from either source, straps presented while it is low
  task automatic reset_cycle(input logic [9:0] s, input logic via_pci);
    @(posedge clk);
    strap <= s;
    if (via_pci) begin
      pci_rst_n <= 1'b0;
    end else begin
      loc_rst_n <= 1'b0;
    end
    repeat (6) @(posedge clk);
    pci_rst_n <= 1'b1;
    loc_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // pins turn functional after reset, so they carry other traffic
    strap <= ~s;
  endtask
endmodule

// ===== testbench/tb.sv
// self-checking bench for the reset strap configuration sampler
`timescale 1ns/1ps
module tb;
  import rscfg_pkg::*;
  logic        core_clk;
  logic        rst_n;
  logic        wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_dat, wb_dat_o, rd;
  logic [9:0]  strap, s;
  logic        pci_rst_n, loc_rst_n, pci_int_n, loc_int_n, pci_pull, loc_pull;
  logic        pci_oe, pci_o, loc_oe, loc_o, tgt_req, tgt_retry, tgt_go;
  logic [7:0]  modes;
  logic        tm0;
  int          seed, mismatches, checked;

  rscfg_board u_rscfg_board (.clk(core_clk), .pci_pull(pci_pull), .loc_pull(loc_pull),
    .pci_int_oe(pci_oe), .pci_int_o(pci_o), .loc_int_oe(loc_oe), .loc_int_o(loc_o),
    .strap(strap), .pci_rst_n(pci_rst_n), .loc_rst_n(loc_rst_n),
    .pci_int_n(pci_int_n), .loc_int_n(loc_int_n));

  rscfg_top u_rscfg_top (.CORE_CLK(core_clk), .RST_N(rst_n), .WB_CYC_I(wb_cyc),
    .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel),
    .WB_DAT_I(wb_dat), .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack),
    .BURST_IN_PROGRESS_STRAP(strap[0]), .SIZE_BIT_ONE_STRAP(strap[1]),
    .SERIAL_DATA_STRAP(strap[2]), .EEPROM_ENABLE_STRAP(strap[3]),
    .TEST_MODE_STRAPS(strap[5:4]), .BUS_MASTER_ENABLE_STRAP(strap[6]),
    .ARBITER_ENABLE_STRAP(strap[7]), .PCI_DISABLE_STRAP(strap[8]),
    .PCI_RST_N(pci_rst_n), .LOCAL_RESET_IN_N(loc_rst_n),
    .PCI_INT_N_I(pci_int_n), .PCI_INT_N_O(pci_o), .PCI_INT_N_OE(pci_oe),
    .LOCAL_INT_N_I(loc_int_n), .LOCAL_INT_N_O(loc_o), .LOCAL_INT_N_OE(loc_oe),
    .TGT_REQ(tgt_req), .TGT_RETRY(tgt_retry), .TGT_GO(tgt_go),
    .M68K_MODE(modes[7]), .EEPROM_PRESENT(modes[6]), .TEST_TRISTATE(modes[5]),
    .TEST_NAND_TREE(modes[4]), .ARBITER_ENABLE(modes[3]), .PCI_ENABLE(modes[2]),
    .PCI_INITIATOR_EN(modes[1]), .CONFIG_LOADED(modes[0]));

  // ************************************************************
  // expectations
  // ************************************************************
  function automatic logic [7:0] exp_modes(input logic [9:0] v);
    return {v[0] & ~v[1], v[3] & v[2], v[5:4] == 2'h1 || v[5:4] == 2'h3,
            v[5:4] == 2'h2, v[7], ~v[8], v[6], 1'b1};
  endfunction

  function automatic logic [31:0] exp_sts(input logic [9:0] v);
    return {20'h00000, v[3] & v[2], v[0] & ~v[1], 1'b0, v[8:0]};
  endfunction

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic cycle: hold until ack is sampled high at a rising edge, take the
  // data and release at that same edge; only the watchdog ends a stuck wait
  task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                    input logic [31:0] dat, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_sel <= sel;
    wb_dat <= dat;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    // the slave answers one cycle after it first sees the request
    check(32'(n), 32'h2);
    // let registers written at the ack edge settle before callers look
    @(negedge core_clk);
  endtask

  // interrupt pass-through passes a filter, so poll under a bound
  task automatic wait_oe(input logic pci, input logic exp, input int mn);
    int n;
    n = 0;
    while (n < mn || ((pci ? pci_oe : loc_oe) !== exp && n < 12)) begin
      @(negedge core_clk);
      n++;
    end
    check({31'h0, pci ? pci_oe : loc_oe}, {31'h0, exp});
    check({30'h0, pci_o, loc_o}, 32'h0);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ************************************************************
  // clock, watchdog and main sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat} = '0;
    {rst_n, tgt_req, pci_pull, loc_pull} = '0;
    seed = 68;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    check({24'h0, modes}, 32'h04);
    wb(1'b1, 8'h40, 4'hf, 32'hffffffff, rd);
    wb(1'b0, 8'h40, 4'hf, 32'h0, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      case (i)
        0: s = 10'h000;
        1: s = 10'h3ff;
        2: s = 10'h011;
        3: s = 10'h020;
        4: s = 10'h030;
        5: s = 10'h0cd;
        default: s = 10'($random(seed));
      endcase
      s[2] = s[3];
      u_rscfg_board.reset_cycle(s, i[0] == 1'b0);
      repeat (8) @(negedge core_clk);
      check({24'h0, modes}, {24'h0, exp_modes(s)});
      wb(1'b0, OFS_STRAP_STS, 4'hf, 32'h0, rd);
      check(rd & 32'hfff, exp_sts(s));
      wb(1'b0, OFS_CMD_STAT, 4'hf, 32'h0, rd);
      check({31'h0, rd[BIT_BUS_MASTER]}, {31'h0, s[6]});
      wb(1'b0, OFS_MISC2, 4'hf, 32'h0, rd);
      check({31'h0, rd[BIT_PCI_DISABLE_STRAP]}, {31'h0, s[8]});
      // target gate follows the disable bit until software clears it
      @(posedge core_clk);
      tgt_req <= 1'b1;
      @(negedge core_clk);
      check({30'h0, tgt_retry, tgt_go}, {30'h0, s[8], ~s[8]});
      if (s[8]) begin
        wb(1'b1, OFS_MISC2, 4'hf, 32'h1, rd);
        check({30'h0, tgt_retry, tgt_go}, 32'h2);
        wb(1'b1, OFS_MISC2, 4'hf, 32'h0, rd);
        check({30'h0, tgt_retry, tgt_go}, 32'h1);
      end
      @(posedge core_clk);
      tgt_req <= 1'b0;
      if (!s[6]) begin
        wb(1'b1, OFS_CMD_STAT, 4'he, 32'h4, rd);
        check({31'h0, modes[1]}, 32'h0);
        wb(1'b1, OFS_CMD_STAT, 4'hf, 32'h4, rd);
        check({31'h0, modes[1]}, 32'h1);
      end
      // interrupt routing both ways; any test mode blocks it
      tm0 = (s[5:4] == TMODE_NORMAL);
      wb(1'b1, OFS_INT_CTL, 4'hf, 32'h1, rd);
      @(posedge core_clk);
      pci_pull <= 1'b1;
      wait_oe(1'b0, tm0, tm0 ? 0 : 8);
      @(posedge core_clk);
      pci_pull <= 1'b0;
      // let the looped-back local pin settle before the mode flips
      wait_oe(1'b0, 1'b0, 10);
      wb(1'b1, OFS_INT_CTL, 4'hf, 32'h0, rd);
      @(posedge core_clk);
      loc_pull <= 1'b1;
      wait_oe(1'b1, tm0, tm0 ? 0 : 8);
      @(posedge core_clk);
      loc_pull <= 1'b0;
      wait_oe(1'b1, 1'b0, 0);
    end
    give_verdict();
  end
endmodule
